// ### rtl/pswc_pkg.sv
// Package of constants for the power-state wake controller.
package pswc_pkg;
	// Register byte offsets on the AXI4-Lite bus.
	localparam logic [7:0] PMC_OFF = 8'h00;
	localparam logic [7:0] BYTE_TEST_OFF = 8'h04;
	localparam logic [7:0] INTERRUPT_STATUS_REG_OFF = 8'h08;
	localparam logic [7:0] PHY_CTRL_OFF = 8'h0c;
	// Field positions in the power management control register.
	localparam int READY_BIT = 0;
	localparam int PULSE_SEL_BIT = 3;
	localparam int WAKE_FRAME_EN_BIT = 9;
	localparam int ED_WAKE_EN_BIT = 14;
	localparam int PIN_EN_BIT = 1;
	localparam int WAKEUP_SOURCE_STATUS_LSB = 4;
	localparam int PSTATE_LSB = 12;
	// Interrupt status and PHY control bit positions.
	localparam int PME_INT_BIT = 17;
	localparam int PHY_PDOWN_BIT = 11;
	localparam int PHY_EDPD_BIT = 13;
	// Power-state codes and wakeup-source codes.
	localparam logic [1:0] PS_NORMAL = 2'h0;
	localparam logic [1:0] PS_WAKE_LISTEN = 2'h1;
	localparam logic [1:0] PS_ENERGY = 2'h2;
	localparam logic [1:0] WAKEUP_SOURCE_STATUS_FRAME = 2'h2;
	localparam logic [1:0] WAKEUP_SOURCE_STATUS_ENERGY = 2'h1;
	// Identity value returned by the byte-test register; arbitrary.
	localparam logic [31:0] BYTE_TEST_VAL = 32'h1234_5678;
	// AXI responses.
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Timing: 10 MHz clock, _US figures in microseconds, _CYC figures in clock cycles.
	localparam int CLK_MHZ = 10;
	localparam int READY_MAX_US = 2000;
	localparam int PULSE_US = 50000;
	localparam int WAKE_DELAY_CYC = 16;
	localparam int READY_MAX_CYC = READY_MAX_US * CLK_MHZ;
	localparam int PULSE_CYC = PULSE_US * CLK_MHZ;
	localparam int PHY_RST_CYC = 8;
	// Sleep controller states.
	typedef enum logic [3:0]
	{
		ST_NORMAL = 4'b0001,
		ST_LISTEN = 4'b0010,
		ST_ENERGY = 4'b0100,
		ST_WAKING = 4'b1000
	} pswc_state_e;
endpackage
`default_nettype wire

// ### rtl/pswc_sync.sv
// Two-flop synchroniser for an asynchronous level.
`timescale 1ns/10ps
`default_nettype none
module pswc_sync
(
	// Clock and control.
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	// Data.
	input wire logic d,
	output logic q
);
	logic meta_reg;
	// The first flop feeds only the second.
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			meta_reg <= 1'b0;
			q <= 1'b0;
		end
		else if (ce)
		begin
			meta_reg <= d;
			q <= meta_reg;
		end
	end
endmodule // pswc_sync
`default_nettype wire

// ### rtl/pswc_pulse.sv
// Down-counter that times the pulsed power-event output.
`timescale 1ns/10ps
`default_nettype none
module pswc_pulse
#(
	parameter int CYCLES = 500000
)
(
	// Clock and control.
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	// Start and abort.
	input wire logic start,
	input wire logic abort,
	output logic busy
);
	logic [31:0] cnt_reg;
	// A fresh event restarts the full width; abort wins so a cleared source drops the pin.
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			cnt_reg <= 32'h0;
		else if (ce)
		begin
			if (abort)
				cnt_reg <= 32'h0;
			else if (start)
				cnt_reg <= 32'(CYCLES);
			else if (cnt_reg != 32'h0)
				cnt_reg <= cnt_reg - 32'h1;
		end
	end
	assign busy = (cnt_reg != 32'h0);
endmodule // pswc_pulse
`default_nettype wire

// ### rtl/pswc_ctrl.sv
// Power-state and wake controller with AXI4-Lite register access.
`timescale 1ns/10ps
`default_nettype none
module pswc_ctrl
#(
	parameter int PULSE_CYCLES = pswc_pkg::PULSE_CYC
)
(
	// Clock, reset, clock enable.
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	// AXI4-Lite write address and data.
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response.
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read.
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Wake detectors, asynchronous to clk.
	input wire logic wake_frame_seen,
	input wire logic carrier_seen,
	// Clock gates and PHY controls.
	output logic mac_clk_en,
	output logic host_clk_en,
	output logic rx_pm_clk_en,
	output logic int_clk_en,
	output logic wake_detect_en,
	output logic phy_edpd,
	output logic phy_pdown,
	output logic phy_reset,
	// Power-event pin, active low open-drain style enable.
	output logic pme_pin_oe_n,
	output logic pme_int
);
	import pswc_pkg::*;

	pswc_state_e state_reg, state_next;
	logic ready_reg, read_seen_reg, wfe_reg, ede_reg, pin_en_reg, psel_reg;
	logic [1:0] wakeup_source_status_reg;
	logic pme_int_reg, phy_pd_reg, phy_ed_reg, pin_level_reg;
	logic [3:0] phy_rst_cnt_reg;
	logic [15:0] wake_cnt_reg;
	logic [31:0] rdata_reg;
	logic aw_held_reg, w_held_reg;
	logic [7:0] awaddr_reg;
	logic [31:0] wdata_reg;
	logic frame_s, carrier_s, pulse_busy;
	logic frame_cond_reg, carrier_cond_reg;

	pswc_sync u_sync_frame (.clk(clk), .rst_n(rst_n), .ce(ce), .d(wake_frame_seen), .q(frame_s));
	pswc_sync u_sync_carrier (.clk(clk), .rst_n(rst_n), .ce(ce), .d(carrier_seen), .q(carrier_s));

	// Write channel capture: address and data may arrive in either order.
	wire wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;
	wire sleeping = (state_reg == ST_LISTEN) || (state_reg == ST_ENERGY);
	wire hit_pmc = (awaddr_reg == PMC_OFF);
	wire hit_bt = (awaddr_reg == BYTE_TEST_OFF);
	wire hit_int = (awaddr_reg == INTERRUPT_STATUS_REG_OFF);
	wire hit_phy = (awaddr_reg == PHY_CTRL_OFF);
	// Writes need a prior read and a ready device, except the wakeup write.
	wire wr_ok = wr_fire && read_seen_reg && ready_reg;
	wire wake_wr = wr_fire && sleeping && hit_bt;
	wire wr_pmc = wr_ok && hit_pmc;
	wire wr_int = wr_ok && hit_int;
	wire wr_phy = wr_ok && hit_phy;
	wire [1:0] new_ps = wdata_reg[PSTATE_LSB+1:PSTATE_LSB];

	// Wake events, only while the matching sleep state is active; one event per rising condition.
	// A carrier already present on entry makes the condition rise at once.
	wire frame_cond = (state_reg == ST_LISTEN) && frame_s;
	wire carrier_cond = (state_reg == ST_ENERGY) && carrier_s;
	wire frame_evt = frame_cond && !frame_cond_reg;
	wire carrier_evt = carrier_cond && !carrier_cond_reg;
	// The interrupt source lives while the source bits and their enable stand.
	wire src_live = (wakeup_source_status_reg == WAKEUP_SOURCE_STATUS_FRAME && wfe_reg) || (wakeup_source_status_reg == WAKEUP_SOURCE_STATUS_ENERGY && ede_reg);
	wire pin_start = (frame_evt && wfe_reg && pin_en_reg) || (carrier_evt && ede_reg && pin_en_reg);
	// The source bits take the event only at the next clock edge, so a fresh event must beat the abort.
	wire pin_abort = (!src_live || !pin_en_reg) && !pin_start;

	pswc_pulse #(.CYCLES(PULSE_CYCLES)) u_pulse
	(
		.clk(clk),
		.rst_n(rst_n),
		.ce(ce),
		.start(pin_start && psel_reg),
		.abort(pin_abort),
		.busy(pulse_busy)
	);

	// State machine.
	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			ST_NORMAL:
				if (wr_pmc && new_ps == PS_WAKE_LISTEN)
					state_next = ST_LISTEN;
				else if (wr_pmc && new_ps == PS_ENERGY)
					state_next = ST_ENERGY;
			ST_LISTEN, ST_ENERGY:
				if (wake_wr)
					state_next = ST_WAKING;
			ST_WAKING:
				if (wake_cnt_reg == 16'(WAKE_DELAY_CYC))
					state_next = ST_NORMAL;
			default:
				state_next = ST_NORMAL;
		endcase
	end

	// State, ready flag and wake delay counter.
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			state_reg <= ST_NORMAL;
			ready_reg <= 1'b1;
			wake_cnt_reg <= 16'h0;
		end
		else if (ce)
		begin
			state_reg <= state_next;
			ready_reg <= (state_next == ST_NORMAL);
			wake_cnt_reg <= (state_reg == ST_WAKING) ? wake_cnt_reg + 16'h1 : 16'h0;
		end
	end

	// Control bits, wakeup source and interrupt status; set wins over clear.
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			wfe_reg <= 1'b0;
			ede_reg <= 1'b0;
			pin_en_reg <= 1'b0;
			psel_reg <= 1'b0;
			wakeup_source_status_reg <= 2'h0;
			pme_int_reg <= 1'b0;
			phy_pd_reg <= 1'b0;
			phy_ed_reg <= 1'b0;
		end
		else if (ce)
		begin
			if (wr_pmc)
			begin
				wfe_reg <= wdata_reg[WAKE_FRAME_EN_BIT];
				ede_reg <= wdata_reg[ED_WAKE_EN_BIT];
				pin_en_reg <= wdata_reg[PIN_EN_BIT];
				psel_reg <= wdata_reg[PULSE_SEL_BIT];
			end
			if (frame_evt)
				wakeup_source_status_reg <= WAKEUP_SOURCE_STATUS_FRAME;
			else if (carrier_evt)
				wakeup_source_status_reg <= WAKEUP_SOURCE_STATUS_ENERGY;
			else if (wr_pmc)
				wakeup_source_status_reg <= wdata_reg[WAKEUP_SOURCE_STATUS_LSB+1:WAKEUP_SOURCE_STATUS_LSB];
			if (frame_evt || carrier_evt)
				pme_int_reg <= 1'b1;
			else if (wr_int && wdata_reg[PME_INT_BIT] && !src_live)
				pme_int_reg <= 1'b0;
			if (wr_phy)
			begin
				phy_pd_reg <= wdata_reg[PHY_PDOWN_BIT];
				phy_ed_reg <= wdata_reg[PHY_EDPD_BIT];
			end
		end
	end

	// Static pin level and PHY reset after general power-down ends.
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			pin_level_reg <= 1'b0;
			phy_rst_cnt_reg <= 4'h0;
			frame_cond_reg <= 1'b0;
			carrier_cond_reg <= 1'b0;
		end
		else if (ce)
		begin
			frame_cond_reg <= frame_cond;
			carrier_cond_reg <= carrier_cond;
			if (pin_start && !psel_reg)
				pin_level_reg <= 1'b1;
			else if (pin_abort || psel_reg)
				pin_level_reg <= 1'b0;
			if (wr_phy && phy_pd_reg && !wdata_reg[PHY_PDOWN_BIT])
				phy_rst_cnt_reg <= 4'(PHY_RST_CYC);
			else if (phy_rst_cnt_reg != 4'h0)
				phy_rst_cnt_reg <= phy_rst_cnt_reg - 4'h1;
		end
	end

	// Registered outputs for clocks, PHY and pin.
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			mac_clk_en <= 1'b1;
			host_clk_en <= 1'b1;
			rx_pm_clk_en <= 1'b1;
			int_clk_en <= 1'b1;
			wake_detect_en <= 1'b0;
			phy_edpd <= 1'b0;
			phy_pdown <= 1'b0;
			phy_reset <= 1'b0;
			pme_pin_oe_n <= 1'b1;
			pme_int <= 1'b0;
		end
		else if (ce)
		begin
			mac_clk_en <= !(state_next == ST_LISTEN || state_next == ST_ENERGY);
			host_clk_en <= !(state_next == ST_LISTEN || state_next == ST_ENERGY);
			rx_pm_clk_en <= (state_next != ST_ENERGY);
			int_clk_en <= (state_next != ST_ENERGY);
			wake_detect_en <= (state_next == ST_LISTEN);
			phy_edpd <= phy_ed_reg || (state_next == ST_ENERGY);
			phy_pdown <= phy_pd_reg;
			phy_reset <= (phy_rst_cnt_reg != 4'h0);
			pme_pin_oe_n <= !(pin_level_reg || pulse_busy);
			pme_int <= pme_int_reg;
		end
	end

	// AXI write path: one outstanding write; unmapped or refused writes still answer.
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			awaddr_reg <= 8'h0;
			wdata_reg <= 32'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end
		else if (ce)
		begin
			s_axi_awready <= !aw_held_reg && !s_axi_awready && s_axi_awvalid;
			s_axi_wready <= !w_held_reg && !s_axi_wready && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_held_reg <= 1'b1;
				awaddr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_held_reg <= 1'b1;
				wdata_reg <= s_axi_wdata;
			end
			if (wr_fire)
			begin
				aw_held_reg <= 1'b0;
				w_held_reg <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (hit_pmc || hit_bt || hit_int || hit_phy) ? RESP_OKAY : RESP_SLVERR;
			end
			else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// Read decode; while asleep only the control register answers.
	wire [1:0] ps_code = (state_reg == ST_LISTEN) ? PS_WAKE_LISTEN :
		(state_reg == ST_ENERGY) ? PS_ENERGY : PS_NORMAL;
	wire [31:0] pmc_word = {17'h0, ede_reg, ps_code, 2'h0, wfe_reg, 3'h0,
		wakeup_source_status_reg, psel_reg, 1'b0, pin_en_reg, ready_reg};
	wire rd_fire = s_axi_arvalid && s_axi_arready;
	wire rd_pmc = (s_axi_araddr == PMC_OFF);
	wire rd_allowed = ready_reg || rd_pmc;
	wire [31:0] rd_word = !rd_allowed ? 32'h0 : rd_pmc ? pmc_word :
		(s_axi_araddr == BYTE_TEST_OFF) ? BYTE_TEST_VAL :
		(s_axi_araddr == INTERRUPT_STATUS_REG_OFF) ? (32'h0 | (32'(pme_int_reg) << PME_INT_BIT)) :
		(s_axi_araddr == PHY_CTRL_OFF) ? ((32'(phy_pd_reg) << PHY_PDOWN_BIT) | (32'(phy_ed_reg) << PHY_EDPD_BIT)) :
		32'h0;
	wire rd_map = rd_pmc || (s_axi_araddr == BYTE_TEST_OFF) || (s_axi_araddr == INTERRUPT_STATUS_REG_OFF)
		|| (s_axi_araddr == PHY_CTRL_OFF);

	// AXI read path and the read-seen flag that unlocks writes.
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= RESP_OKAY;
			read_seen_reg <= 1'b0;
		end
		else if (ce)
		begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
			if (rd_fire)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_word;
				s_axi_rresp <= (rd_map && rd_allowed) ? RESP_OKAY : RESP_SLVERR;
			end
			else if (s_axi_rready)
				s_axi_rvalid <= 1'b0;
			if (state_next != ST_NORMAL && state_reg == ST_NORMAL)
				read_seen_reg <= 1'b0;
			else if (rd_fire && ready_reg)
				read_seen_reg <= 1'b1;
		end
	end

	// Checks of the documented behaviour.
	sequence wake_write_s;
		wake_wr && ce;
	endsequence
	ready_sleep_a: assert property (@(posedge clk) disable iff (!rst_n)
		(state_reg == ST_LISTEN || state_reg == ST_ENERGY) |-> !ready_reg)
		else $error("Ready set while asleep.");
	ready_within_a: assert property (@(posedge clk) disable iff (!rst_n)
		wake_write_s |-> ##[1:40] ready_reg)
		else $error("Ready late after wakeup write.");
	sleep_entry_a: assert property (@(posedge clk) disable iff (!rst_n)
		(ce && wr_pmc && new_ps == PS_WAKE_LISTEN && state_reg == ST_NORMAL) |=> state_reg == ST_LISTEN)
		else $error("Wake-listen not entered.");
	listen_clocks_a: assert property (@(posedge clk) disable iff (!rst_n)
		(ce && state_reg == ST_LISTEN && $past(state_reg) == ST_LISTEN) |-> !mac_clk_en && int_clk_en)
		else $error("Wake-listen clock gating wrong.");
	frame_wakeup_source_status_a: assert property (@(posedge clk) disable iff (!rst_n)
		(ce && frame_evt) |=> wakeup_source_status_reg == WAKEUP_SOURCE_STATUS_FRAME && pme_int_reg)
		else $error("Frame wake not recorded.");
	carrier_wakeup_source_status_a: assert property (@(posedge clk) disable iff (!rst_n)
		(ce && carrier_evt) |=> wakeup_source_status_reg == WAKEUP_SOURCE_STATUS_ENERGY && pme_int_reg)
		else $error("Carrier wake not recorded.");
	int_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
		(pme_int_reg && src_live) |=> pme_int_reg)
		else $error("Interrupt status dropped while source live.");
	pin_drop_a: assert property (@(posedge clk) disable iff (!rst_n)
		(ce && !pin_en_reg) |=> ##1 pme_pin_oe_n)
		else $error("Pin still driven with pin disabled.");
	write_lock_a: assert property (@(posedge clk) disable iff (!rst_n)
		(wr_fire && !read_seen_reg && ce) |=> $stable(wfe_reg))
		else $error("Write took effect before first read.");
endmodule // pswc_ctrl
`default_nettype wire

// ### sim/pswc_host_model.sv
// Host processor model that runs single AXI4-Lite accesses for the bench.
`timescale 1ns/10ps
`default_nettype none
module pswc_host_model
(
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_n,
	// Commands from the bench.
	input wire logic req,
	input wire logic wr,
	input wire logic slow,
	input wire logic [7:0] addr,
	input wire logic [31:0] data,
	output logic done,
	output logic [31:0] cmd_rdata,
	output logic [1:0] cmd_resp,
	// AXI4-Lite master side.
	output logic [7:0] s_axi_awaddr,
	output logic s_axi_awvalid,
	input wire logic s_axi_awready,
	output logic [31:0] s_axi_wdata,
	output logic [3:0] s_axi_wstrb,
	output logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	output logic s_axi_bready,
	output logic [7:0] s_axi_araddr,
	output logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	output logic s_axi_rready
);
	// The slave ignores strobes, so every write is a full word.
	assign s_axi_wstrb = 4'hf;
	// Idle values at time zero, before the first reset edge.
	initial
	begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, s_axi_bready, s_axi_rready, done} = 6'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
	end
	// One access at a time; a slow host raises ready only once the answer shows.
	always @(posedge clk)
	begin
		done <= 1'b0;
		if (!rst_n)
			{s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, s_axi_bready, s_axi_rready} <= 5'h0;
		else if (req && wr)
		begin
			{s_axi_awaddr, s_axi_wdata} <= {addr, data};
			{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {2'h3, !slow};
		end
		else if (req)
			{s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {addr, 1'b1, !slow};
		else
		begin
			// Released lines show the inverse, so a stale value cannot pass for a held one.
			if (s_axi_awvalid && s_axi_awready)
				{s_axi_awvalid, s_axi_awaddr} <= {1'b0, ~s_axi_awaddr};
			if (s_axi_wvalid && s_axi_wready)
				{s_axi_wvalid, s_axi_wdata} <= {1'b0, ~s_axi_wdata};
			if (s_axi_arvalid && s_axi_arready)
				{s_axi_arvalid, s_axi_araddr} <= {1'b0, ~s_axi_araddr};
			if (s_axi_bvalid && s_axi_bready)
				{s_axi_bready, done, cmd_resp} <= {2'h1, s_axi_bresp};
			else if (s_axi_bvalid)
				s_axi_bready <= 1'b1;
			if (s_axi_rvalid && s_axi_rready)
				{s_axi_rready, done, cmd_resp, cmd_rdata} <= {2'h1, s_axi_rresp, s_axi_rdata};
			else if (s_axi_rvalid)
				s_axi_rready <= 1'b1;
		end
	end
endmodule // pswc_host_model
`default_nettype wire

// ### sim/pswc_ctrl_tb.sv
// Self-checking bench for the power-state wake controller.
`timescale 1ns/10ps
`default_nettype none
module pswc_ctrl_tb;
	import pswc_pkg::*;
	localparam int PCYC = 20;
	logic clk, rst_n, req, wr, slow, done, wake_frame_seen, carrier_seen;
	logic [7:0] addr, s_axi_awaddr, s_axi_araddr;
	logic [31:0] data, rd, cmd_rdata, s_axi_wdata, s_axi_rdata, v;
	logic [1:0] rs, cmd_resp, s_axi_bresp, s_axi_rresp;
	logic [3:0] s_axi_wstrb;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic mac_clk_en, host_clk_en, rx_pm_clk_en, int_clk_en, wake_detect_en;
	logic phy_edpd, phy_pdown, phy_reset, pme_pin_oe_n, pme_int;
	int err_total, compares, low_cnt, rst_cnt, cnt, t0, k;

	pswc_ctrl #(.PULSE_CYCLES(PCYC)) dut (.clk, .rst_n, .ce(1'b1), .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .wake_frame_seen, .carrier_seen, .mac_clk_en,
		.host_clk_en, .rx_pm_clk_en, .int_clk_en, .wake_detect_en, .phy_edpd, .phy_pdown, .phy_reset,
		.pme_pin_oe_n, .pme_int);
	pswc_host_model host (.clk, .rst_n, .req, .wr, .slow, .addr, .data, .done, .cmd_rdata, .cmd_resp,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

	// Clock at 10 MHz.
	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// Cycle count, pin-active length and PHY reset length.
	always @(posedge clk)
	begin
		cnt <= cnt + 1;
		if (!pme_pin_oe_n)
			low_cnt <= low_cnt + 1;
		if (phy_reset)
			rst_cnt <= rst_cnt + 1;
	end
	// Cuts a hang short.
	initial
	begin
		repeat (100000) @(posedge clk);
		err_total++;
		results();
	end

	task results;
		$display("Comparisons %0d, mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			err_total++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// One access; the answer is waited for under a bound.
	task acc(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		req <= 1'b1;
		wr <= w;
		addr <= a;
		data <= d;
		cyc(1);
		req <= 1'b0;
		for (i = 0; i < 40 && done !== 1'b1; i++)
			cyc(1);
		if (done !== 1'b1)
		begin
			err_total++;
			results();
		end
		rd = cmd_rdata;
		rs = cmd_resp;
	endtask
	// Expected control-register word.
	function automatic logic [31:0] pmc(input logic rdy, input logic pin, input logic psel, input logic wfe,
		input logic ede, input logic [1:0] wakeup_source_status, input logic [1:0] st);
		logic [31:0] r;
		r = 32'h0;
		{r[READY_BIT], r[PIN_EN_BIT], r[PULSE_SEL_BIT], r[WAKE_FRAME_EN_BIT], r[ED_WAKE_EN_BIT]} = {rdy, pin, psel, wfe, ede};
		r[WAKEUP_SOURCE_STATUS_LSB +: 2] = wakeup_source_status;
		r[PSTATE_LSB +: 2] = st;
		return r;
	endfunction
	// Wakeup write, then only control-register reads until ready returns.
	task wake;
		t0 = cnt;
		acc(1'h1, BYTE_TEST_OFF, $urandom);
		rd = 32'h0;
		for (k = 0; k < 500 && rd[READY_BIT] !== 1'b1; k++)
			acc(1'h0, PMC_OFF, 32'h0);
		chk(32'(cnt - t0 <= READY_MAX_CYC), 32'h1);
		if (rd[READY_BIT] !== 1'b1)
			results();
	endtask

	// Main sequence.
	initial
	begin
		{req, wr, slow, wake_frame_seen, carrier_seen, rst_n} = 6'h0;
		{addr, data, err_total, compares, low_cnt, rst_cnt, cnt} = 'h0;
		void'($urandom(32'h6bf3acea));
		cyc(5);
		rst_n <= 1'b1;
		chk({mac_clk_en, host_clk_en, rx_pm_clk_en, int_clk_en, pme_pin_oe_n, pme_int}, 32'h3e);
		// A write before the first read must have no effect.
		acc(1'h1, PMC_OFF, pmc(1'h0, 1'h1, 1'h1, 1'h1, 1'h1, 2'h0, PS_WAKE_LISTEN));
		acc(1'h0, PMC_OFF, 32'h0);
		chk(rd, pmc(1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 2'h0, PS_NORMAL));
		acc(1'h0, BYTE_TEST_OFF, 32'h0);
		chk(rd, BYTE_TEST_VAL);
		acc(1'h0, 8'h10, 32'h0);
		chk({rd, rs}, {32'h0, RESP_SLVERR});
		for (int j = 0; j < 6; j++)
		begin
			v = $urandom;
			slow <= v[20];
			acc(1'h1, PMC_OFF, pmc(1'h0, v[1], v[3], v[9], v[14], 2'h0, PS_NORMAL));
			acc(1'h0, PMC_OFF, 32'h0);
			chk(rd, pmc(1'h1, v[1], v[3], v[9], v[14], 2'h0, PS_NORMAL));
		end
		// Wake-listen sleep with a steady pin; enables set in the same write.
		acc(1'h1, PMC_OFF, pmc(1'h0, 1'h1, 1'h0, 1'h1, 1'h0, 2'h0, PS_WAKE_LISTEN));
		acc(1'h0, PMC_OFF, 32'h0);
		chk(rd, pmc(1'h0, 1'h1, 1'h0, 1'h1, 1'h0, 2'h0, PS_WAKE_LISTEN));
		chk({mac_clk_en, host_clk_en, rx_pm_clk_en, int_clk_en, wake_detect_en, phy_edpd}, 32'he);
		acc(1'h0, INTERRUPT_STATUS_REG_OFF, 32'h0);
		chk({rd, rs}, {32'h0, RESP_SLVERR});
		cyc($urandom_range(1, 9));
		wake_frame_seen = 1'b1;
		cyc(12);
		chk({pme_pin_oe_n, pme_int}, 32'h1);
		wake_frame_seen = 1'b0;
		acc(1'h0, PMC_OFF, 32'h0);
		chk(rd[WAKEUP_SOURCE_STATUS_LSB +: 2], WAKEUP_SOURCE_STATUS_FRAME);
		wake();
		chk(rd, pmc(1'h1, 1'h1, 1'h0, 1'h1, 1'h0, WAKEUP_SOURCE_STATUS_FRAME, PS_NORMAL));
		chk({mac_clk_en, host_clk_en, rx_pm_clk_en, int_clk_en, wake_detect_en}, 32'h1e);
		acc(1'h1, INTERRUPT_STATUS_REG_OFF, 32'h1 << PME_INT_BIT);
		cyc(2);
		chk({pme_int, pme_pin_oe_n}, 32'h2);
		acc(1'h1, PMC_OFF, pmc(1'h0, 1'h1, 1'h0, 1'h1, 1'h0, 2'h0, PS_NORMAL));
		cyc(2);
		chk({pme_int, pme_pin_oe_n}, 32'h3);
		acc(1'h1, INTERRUPT_STATUS_REG_OFF, 32'h1 << PME_INT_BIT);
		cyc(2);
		chk(pme_int, 1'b0);
		// Energy sleep entered with carrier already present, pulsed pin.
		acc(1'h1, PHY_CTRL_OFF, 32'h1 << PHY_EDPD_BIT);
		carrier_seen = 1'b1;
		cyc(4);
		low_cnt = 0;
		acc(1'h1, PMC_OFF, pmc(1'h0, 1'h1, 1'h1, 1'h0, 1'h1, 2'h0, PS_ENERGY));
		chk({mac_clk_en, host_clk_en, rx_pm_clk_en, int_clk_en, phy_edpd}, 32'h1);
		cyc(PCYC + 20);
		chk({32'(low_cnt >= PCYC - 1 && low_cnt <= PCYC + 1), pme_int}, 32'h3);
		carrier_seen = 1'b0;
		wake();
		chk(rd[WAKEUP_SOURCE_STATUS_LSB +: 2], WAKEUP_SOURCE_STATUS_ENERGY);
		acc(1'h1, PHY_CTRL_OFF, 32'h0);
		acc(1'h1, PMC_OFF, pmc(1'h0, 1'h1, 1'h1, 1'h0, 1'h0, WAKEUP_SOURCE_STATUS_ENERGY, PS_NORMAL));
		acc(1'h1, INTERRUPT_STATUS_REG_OFF, 32'h1 << PME_INT_BIT);
		cyc(2);
		chk({phy_edpd, pme_int}, 32'h0);
		// General PHY power-down, then power-up with its reset pulse.
		acc(1'h1, PHY_CTRL_OFF, 32'h1 << PHY_PDOWN_BIT);
		cyc(2);
		chk(phy_pdown, 1'b1);
		rst_cnt = 0;
		acc(1'h1, PHY_CTRL_OFF, 32'h0);
		cyc(PHY_RST_CYC + 4);
		chk(phy_pdown, 1'b0);
		chk(rst_cnt, PHY_RST_CYC);
		results();
	end
endmodule // pswc_ctrl_tb
`default_nettype wire
